//--- common/rxd_cfg.svh
// Purpose: Constants for the receive descriptor engine
// Assumes: 125 MHz system clock
// Notes:   Word indices count 32-bit words inside one descriptor
`ifndef RXD_CFG_SVH
`define RXD_CFG_SVH

// Descriptor word indices
`define RXD_W_STAT        3'h0
`define RXD_W_CTRL        3'h1
`define RXD_W_PTR1        3'h2
`define RXD_W_PTR2        3'h3
`define RXD_W_EXT         3'h4
`define RXD_W_RESV        3'h5
`define RXD_W_TSLO        3'h6
`define RXD_W_TSHI        3'h7

// Word 0 field positions
`define RXD_W0_OWN        31
`define RXD_W0_LAST       8
`define RXD_W0_TSV        7
`define RXD_W0_EXSV       0

// Word 1 field positions
`define RXD_W1_RING_END   15
`define RXD_W1_CHAIN      14
`define RXD_W1_SIZE1_MSB  12
`define RXD_W1_SIZE2_LSB  16
`define RXD_W1_SIZE2_MSB  28

// Word 4 header error bit
`define RXD_W4_HDR_ERR    3

// Descriptor stride in bytes, normal and enhanced layout
`define RXD_STRIDE_NORM   32'h0000_0010
`define RXD_STRIDE_ENH    32'h0000_0020

// Ether types and IP versions
`define RXD_ETYPE_IPV4    16'h0800
`define RXD_ETYPE_IPV6    16'h86dd
`define RXD_IPVER_4       4'h4
`define RXD_IPVER_6       4'h6

// Internal DMA event positions
`define RXD_EVT_DONE      0
`define RXD_EVT_UNAVAIL   4

// Internal reset duration
`define RXD_CLK_MHZ       125
`define RXD_SWR_TIME_NS   64
`define RXD_SWR_CYCLES    ((`RXD_SWR_TIME_NS * `RXD_CLK_MHZ + 999) / 1000)

`endif

//--- common/rxd_pkg.sv
// Purpose: Types for the receive descriptor engine
// Assumes: Nothing beyond the config header
// Notes:   One-hot state codes
package rxd_pkg;

  typedef enum logic [5:0] {
    st_reset = 6'h01,
    st_idle  = 6'h02,
    st_fetch = 6'h04,
    st_ready = 6'h08,
    st_wb    = 6'h10,
    st_next  = 6'h20
  } rxd_state_t;

  // Per-buffer frame status from the receive path
  typedef struct packed {
    logic        ts_en;
    logic        filt_pass;
    logic        snap_hit;
    logic [63:0] ts;
    logic        ptp_version_flag;
    logic        ptp_over_ethernet_flag;
    logic [3:0]  ptp_message_type_field;
    logic        ipv6_frame_flag;
    logic        ipv4_frame_flag;
    logic        checksum_bypassed_flag;
    logic        l4_cksum_bad;
    logic [15:0] ip_len;
    logic [15:0] pld_len;
    logic        ip_hdr_cksum_bad;
    logic [15:0] ether_type;
    logic [3:0]  ip_ver;
    logic        checksum_offload_enable;
    logic [2:0]  pld_type;
    logic [31:0] status0;
  } rxd_frame_t;

  // One descriptor write-back word
  typedef struct packed {
    logic        valid;
    logic [2:0]  idx;
    logic [31:0] data;
  } rxd_wb_t;

endpackage : rxd_pkg

//--- hw/rxd_desc_mem.sv
// Purpose: Local copy of the current receive descriptor
// Assumes: One write port, one read port, same clock
// Notes:   Read data is registered, one cycle latency
`timescale 1ns/1ps
module rxd_desc_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 32
) (
  input  wire logic                     clk_i,
  input  wire logic                     arst_n_i,
  input  wire logic                     we_i,
  input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input  wire logic [WIDTH-1:0]         wdata_i,
  input  wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic      [WIDTH-1:0]         rdata_o
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  // A one-word store would leave the address ports with no bits
  if (DEPTH < 2 || WIDTH < 1)
  begin : g_bad_param
    $error("rxd_desc_mem: unsupported size");
  end

  // Storage has no reset; only the read register does
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem_reg[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_o <= '0;
    end
    else
    begin
      rdata_o <= mem_reg[raddr_i];
    end
  end

endmodule : rxd_desc_mem

//--- hw/rxd_engine.sv
// Purpose: Receive descriptor handling, reset, poll demand and interrupts
// Assumes: Fetch unit loads a descriptor into the local copy before desc_valid_i
`timescale 1ns/1ps
`include "rxd_cfg.svh"
module rxd_engine #(
  parameter int NUM_MAC_EVT = 4,
  parameter int NUM_DMA_EVT = 8,
  parameter int NUM_NORMAL  = 4
) (
  input  wire logic                   clk_i,
  input  wire logic                   arst_n_i,
  input  wire logic [31:0]            desc_base_i,
  input  wire logic                   descriptor_format_mode_i,
  input  wire logic                   sw_reset_req_i,
  output logic                        software_reset_bit_o,
  output logic                        fetch_req_o,
  output logic      [31:0]            fetch_addr_o,
  input  wire logic                   desc_load_i,
  input  wire logic [2:0]             desc_load_idx_i,
  input  wire logic [31:0]            desc_load_data_i,
  input  wire logic                   desc_valid_i,
  output logic                        store_en_o,
  output logic      [31:0]            store_addr_o,
  output logic                        buf2_en_o,
  output logic      [31:0]            buf2_addr_o,
  input  wire logic                   buf_full_i,
  input  wire logic                   frame_last_i,
  input  wire rxd_pkg::rxd_frame_t    frame_i,
  output rxd_pkg::rxd_wb_t            wb_o,
  input  wire logic                   wb_ready_i,
  output logic                        next_valid_o,
  output logic      [31:0]            next_addr_o,
  input  wire logic                   tx_poll_write_i,
  output logic                        tx_poll_demand_o,
  input  wire logic [NUM_MAC_EVT-1:0] mac_flags_i,
  input  wire logic [NUM_MAC_EVT-1:0] mac_mask_i,
  input  wire logic [NUM_DMA_EVT-1:0] dma_evt_i,
  input  wire logic [NUM_DMA_EVT-1:0] dma_en_i,
  input  wire logic [NUM_DMA_EVT-1:0] dma_clr_i,
  output logic      [NUM_DMA_EVT-1:0] dma_status_o,
  output logic                        normal_sum_o,
  output logic                        abnormal_sum_o,
  input  wire logic                   wake_evt_i,
  input  wire logic                   wake_mask_i,
  output logic                        irq_o,
  output logic                        wake_irq_o
);

  // Internal event slots must exist on both sides of the split
  if (NUM_DMA_EVT <= `RXD_EVT_UNAVAIL || NUM_NORMAL <= `RXD_EVT_DONE ||
      NUM_NORMAL > `RXD_EVT_UNAVAIL || NUM_MAC_EVT < 1)
  begin : g_bad_param
    $error("rxd_engine: unsupported event counts");
  end

  function automatic logic ip_frame(input rxd_pkg::rxd_frame_t f);
    ip_frame = f.ipv4_frame_flag | f.ipv6_frame_flag;
  endfunction : ip_frame

  rxd_pkg::rxd_state_t state_reg, state_next;
  rxd_pkg::rxd_frame_t frm_reg, frm_next;
  logic [2:0]  cnt_reg, cnt_next, wb_idx_reg, wb_idx_next;
  logic [31:0] w0_reg, w0_next, w1_reg, w1_next, w2_reg, w2_next, w3_reg, w3_next;
  logic [31:0] cur_reg, cur_next, next_addr_reg, next_addr_next, rdata;
  logic        last_reg, last_next, next_valid_reg, next_valid_next;
  logic        rx_done_pulse, unavail_pulse;
  logic        ts_ok, hdr_err, pld_err, rx_chain_flag, rx_ring_end_flag;
  logic [12:0] rx_buffer_one_size, rx_buffer_two_size;
  logic [7:0]  wb_mask;
  logic [31:0] wb_word [8];

  rxd_desc_mem #(.DEPTH(8), .WIDTH(32)) u_mem (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .we_i     (desc_load_i),
    .waddr_i  (desc_load_idx_i),
    .wdata_i  (desc_load_data_i),
    .raddr_i  (cnt_reg),
    .rdata_o  (rdata)
  );

  // Control word fields
  assign rx_ring_end_flag   = w1_reg[`RXD_W1_RING_END];
  assign rx_chain_flag      = w1_reg[`RXD_W1_CHAIN];
  assign rx_buffer_one_size = w1_reg[`RXD_W1_SIZE1_MSB:0];
  assign rx_buffer_two_size = w1_reg[`RXD_W1_SIZE2_MSB:`RXD_W1_SIZE2_LSB];

  // Buffer pointers offered while waiting for data
  // store gate
  assign store_en_o   = (state_reg == rxd_pkg::st_ready) && (rx_buffer_one_size != 13'h0);
  assign store_addr_o = w2_reg;
  assign buf2_en_o    = (state_reg == rxd_pkg::st_ready) && !rx_chain_flag &&
                        (rx_buffer_two_size != 13'h0);
  assign buf2_addr_o  = w3_reg;
  assign fetch_req_o  = (state_reg == rxd_pkg::st_idle);
  assign fetch_addr_o = cur_reg;
  assign next_valid_o = next_valid_reg;
  assign next_addr_o  = next_addr_reg;

  // Write-back words built from the captured frame status
  always_comb
  begin
    ts_ok   = frm_reg.ts_en & frm_reg.filt_pass & frm_reg.snap_hit & last_reg;
    hdr_err = frm_reg.ip_hdr_cksum_bad |
              ((frm_reg.ether_type == `RXD_ETYPE_IPV4) && (frm_reg.ip_ver != `RXD_IPVER_4)) |
              ((frm_reg.ether_type == `RXD_ETYPE_IPV6) && (frm_reg.ip_ver != `RXD_IPVER_6));
    // payload check, only meaningful for IP
    pld_err = ip_frame(frm_reg) &
              (frm_reg.l4_cksum_bad | (frm_reg.ip_len != frm_reg.pld_len));
    wb_word[`RXD_W_STAT] = frm_reg.status0;
    wb_word[`RXD_W_STAT][`RXD_W0_OWN]  = 1'b0;
    wb_word[`RXD_W_STAT][`RXD_W0_LAST] = last_reg;
    if (descriptor_format_mode_i)
    begin
      wb_word[`RXD_W_STAT][`RXD_W0_TSV]  = ts_ok;
      wb_word[`RXD_W_STAT][`RXD_W0_EXSV] = last_reg;
    end
    wb_word[`RXD_W_CTRL] = w1_reg;
    wb_word[`RXD_W_PTR1] = frm_reg.ts[31:0];
    wb_word[`RXD_W_PTR2] = frm_reg.ts[63:32];
    wb_word[`RXD_W_EXT]  = {18'h0, frm_reg.ptp_version_flag, frm_reg.ptp_over_ethernet_flag,
                            frm_reg.ptp_message_type_field, frm_reg.ipv6_frame_flag,
                            frm_reg.ipv4_frame_flag,
                            frm_reg.checksum_bypassed_flag & ip_frame(frm_reg),
                            pld_err, hdr_err,
                            (frm_reg.checksum_offload_enable && !hdr_err && last_reg) ?
                              frm_reg.pld_type : 3'h0};
    wb_word[`RXD_W_RESV] = 32'h0;
    wb_word[`RXD_W_TSLO] = frm_reg.ts[31:0];
    wb_word[`RXD_W_TSHI] = frm_reg.ts[63:32];
    // word 5 and word 1 never written
    wb_mask = 8'h01;
    wb_mask[`RXD_W_PTR1] = ts_ok & !descriptor_format_mode_i;
    wb_mask[`RXD_W_PTR2] = ts_ok & !descriptor_format_mode_i;
    wb_mask[`RXD_W_EXT]  = descriptor_format_mode_i & last_reg;
    wb_mask[`RXD_W_TSLO] = ts_ok & descriptor_format_mode_i;
    wb_mask[`RXD_W_TSHI] = ts_ok & descriptor_format_mode_i;
  end

  // Write-back port is a mux of stable registers
  assign wb_o.valid = (state_reg == rxd_pkg::st_wb) && wb_mask[wb_idx_reg];
  assign wb_o.idx   = wb_idx_reg;
  assign wb_o.data  = wb_word[wb_idx_reg];

  // Descriptor walk: fetch, wait for data, write back, advance
  always_comb
  begin
    state_next      = state_reg;
    cnt_next        = cnt_reg;
    w0_next         = w0_reg;
    w1_next         = w1_reg;
    w2_next         = w2_reg;
    w3_next         = w3_reg;
    frm_next        = frm_reg;
    last_next       = last_reg;
    wb_idx_next     = wb_idx_reg;
    cur_next        = cur_reg;
    next_addr_next  = next_addr_reg;
    next_valid_next = 1'b0;
    rx_done_pulse   = 1'b0;
    unavail_pulse   = 1'b0;
    if (software_reset_bit_o)
    begin
      // engine held while the internal reset runs
      state_next = rxd_pkg::st_reset;
      cur_next   = desc_base_i;
    end
    else
    begin
      unique case (state_reg)
        rxd_pkg::st_reset: state_next = rxd_pkg::st_idle;
        rxd_pkg::st_idle:
        begin
          if (desc_valid_i)
          begin
            state_next = rxd_pkg::st_fetch;
            cnt_next   = 3'h0;
          end
        end
        rxd_pkg::st_fetch:
        begin
          // Read data trails the address by one cycle
          cnt_next = cnt_reg + 3'h1;
          unique case (cnt_reg)
            3'h1:    w0_next = rdata;
            3'h2:    w1_next = rdata;
            3'h3:    w2_next = rdata;
            3'h4:    w3_next = rdata;
            default: ;
          endcase
          if (cnt_reg == 3'h4)
          begin
            // software owned descriptor stalls the walk
            if (w0_reg[`RXD_W0_OWN])
            begin
              state_next = rxd_pkg::st_ready;
            end
            else
            begin
              state_next    = rxd_pkg::st_idle;
              unavail_pulse = 1'b1;
            end
          end
        end
        rxd_pkg::st_ready:
        begin
          if (frame_last_i || buf_full_i)
          begin
            frm_next    = frame_i;
            last_next   = frame_last_i;
            wb_idx_next = 3'h0;
            state_next  = rxd_pkg::st_wb;
          end
        end
        rxd_pkg::st_wb:
        begin
          if (!wb_mask[wb_idx_reg] || wb_ready_i)
          begin
            wb_idx_next = wb_idx_reg + 3'h1;
            if (wb_idx_reg == 3'h7)
            begin
              state_next    = rxd_pkg::st_next;
              rx_done_pulse = last_reg;
            end
          end
        end
        rxd_pkg::st_next:
        begin
          // ring end wins over the link
          if (rx_ring_end_flag)
          begin
            next_addr_next = desc_base_i;
          end
          else if (rx_chain_flag)
          begin
            next_addr_next = w3_reg;
          end
          else
          begin
            next_addr_next = cur_reg + (descriptor_format_mode_i ?
                                        `RXD_STRIDE_ENH : `RXD_STRIDE_NORM);
          end
          cur_next        = next_addr_next;
          next_valid_next = 1'b1;
          state_next      = rxd_pkg::st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_reg      <= rxd_pkg::st_reset;
      cnt_reg        <= 3'h0;
      w0_reg         <= 32'h0;
      w1_reg         <= 32'h0;
      w2_reg         <= 32'h0;
      w3_reg         <= 32'h0;
      frm_reg        <= '0;
      last_reg       <= 1'b0;
      wb_idx_reg     <= 3'h0;
      cur_reg        <= 32'h0;
      next_addr_reg  <= 32'h0;
      next_valid_reg <= 1'b0;
    end
    else
    begin
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
      w0_reg         <= w0_next;
      w1_reg         <= w1_next;
      w2_reg         <= w2_next;
      w3_reg         <= w3_next;
      frm_reg        <= frm_next;
      last_reg       <= last_next;
      wb_idx_reg     <= wb_idx_next;
      cur_reg        <= cur_next;
      next_addr_reg  <= next_addr_next;
      next_valid_reg <= next_valid_next;
    end
  end

  // Sticky DMA events; a set in the clearing cycle survives
  logic [NUM_DMA_EVT-1:0] own_evt, stat_next;
  logic                   mac_irq, irq_next;
  always_comb
  begin
    own_evt                   = '0;
    own_evt[`RXD_EVT_DONE]    = rx_done_pulse;
    own_evt[`RXD_EVT_UNAVAIL] = unavail_pulse;
  end
  for (genvar i = 0; i < NUM_DMA_EVT; i++)
  begin : g_evt
    assign stat_next[i] = (dma_status_o[i] & ~dma_clr_i[i]) | dma_evt_i[i] | own_evt[i];
  end
  // summaries fall when events or enables are gone
  assign normal_sum_o   = |(dma_status_o[NUM_NORMAL-1:0] & dma_en_i[NUM_NORMAL-1:0]);
  assign abnormal_sum_o = |(dma_status_o[NUM_DMA_EVT-1:NUM_NORMAL] &
                            dma_en_i[NUM_DMA_EVT-1:NUM_NORMAL]);
  // mask bit high hides its flag
  assign mac_irq  = |(mac_flags_i & ~mac_mask_i);
  // unmasked wake also reaches the main line
  assign irq_next = mac_irq | normal_sum_o | abnormal_sum_o | (wake_evt_i & !wake_mask_i);

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dma_status_o <= '0;
      irq_o        <= 1'b0;
      wake_irq_o   <= 1'b0;
    end
    else
    begin
      dma_status_o <= stat_next;
      irq_o        <= irq_next;
      wake_irq_o   <= wake_evt_i;
    end
  end

  // Internal reset timer and poll demand
  logic [7:0] swr_cnt_reg, swr_cnt_next;
  logic       swr_next;
  always_comb
  begin
    swr_next     = software_reset_bit_o;
    swr_cnt_next = swr_cnt_reg;
    // set on request, clear after the timer
    if (sw_reset_req_i)
    begin
      swr_next     = 1'b1;
      swr_cnt_next = 8'h00;
    end
    else if (software_reset_bit_o)
    begin
      swr_cnt_next = swr_cnt_reg + 8'h01;
      if (swr_cnt_reg == 8'(`RXD_SWR_CYCLES - 1))
      begin
        swr_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      software_reset_bit_o <= 1'b1;
      swr_cnt_reg          <= 8'h00;
      tx_poll_demand_o     <= 1'b0;
    end
    else
    begin
      software_reset_bit_o <= swr_next;
      swr_cnt_reg          <= swr_cnt_next;
      tx_poll_demand_o     <= tx_poll_write_i;
    end
  end

  // Checks on the walk, write-back and interrupt paths
  localparam int SWR_MAX = `RXD_SWR_CYCLES;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  ring_base_a: assert property (next_valid_o && rx_ring_end_flag |->
    next_addr_o == desc_base_i) else $error("ring end did not return to base");
  chain_next_a: assert property (next_valid_o && rx_chain_flag && !rx_ring_end_flag |->
    next_addr_o == w3_reg) else $error("chain link not followed");
  size_two_a: assert property (rx_chain_flag |-> !buf2_en_o)
    else $error("second buffer used in chain mode");
  store_gate_a: assert property (store_en_o |-> w1_reg[12:0] != 13'h0)
    else $error("store with zero buffer size");
  ts_low_a: assert property (wb_o.valid && wb_o.idx == 3'h2 |->
    wb_o.data == frm_reg.ts[31:0] && frm_reg.snap_hit) else $error("word 2 not timestamp");
  ts_enh_a: assert property (wb_o.valid && wb_o.idx == 3'h7 |->
    descriptor_format_mode_i && wb_o.data == frm_reg.ts[63:32]) else $error("word 7 bad");
  resv_word_a: assert property (wb_o.valid |-> wb_o.idx != 3'h5)
    else $error("reserved word written");
  pld_type_a: assert property (wb_o.valid && wb_o.idx == 3'h4 && wb_o.data[3] |->
    wb_o.data[2:0] == 3'h0) else $error("payload type with header error");
  hdr_type_a: assert property (wb_o.valid && wb_o.idx == 3'h4 &&
    frm_reg.ether_type == 16'h0800 && frm_reg.ip_ver != 4'h4 |-> wb_o.data[3])
    else $error("type and version mismatch not flagged");
  owner_last_a: assert property (wb_o.valid && wb_o.idx == 3'h0 |->
    !wb_o.data[31] && wb_o.data[8] == last_reg) else $error("word 0 flags wrong");
  swr_done_a: assert property (software_reset_bit_o && !sw_reset_req_i |->
    ##[1:SWR_MAX] !software_reset_bit_o || sw_reset_req_i) else $error("reset bit stuck");
  poll_a: assert property (tx_poll_write_i |=> tx_poll_demand_o)
    else $error("poll demand lost");
  set_wins_a: assert property (dma_evt_i[1] && dma_clr_i[1] |=> dma_status_o[1])
    else $error("event lost on clear");
  irq_hold_a: assert property ((normal_sum_o || abnormal_sum_o || mac_irq) |=> irq_o)
    else $error("interrupt dropped while pending");
  wake_both_a: assert property (wake_evt_i && !wake_mask_i |=> irq_o && wake_irq_o)
    else $error("wake event not on both lines");

  chain_walk_c: cover property (next_valid_o && rx_chain_flag && !rx_ring_end_flag);
  ts_wb_c: cover property (wb_o.valid && wb_ready_i && wb_o.idx == 3'h6);
  unavail_c: cover property (unavail_pulse);
  wake_c: cover property (wake_irq_o && irq_o);

endmodule : rxd_engine

//--- tb/rxd_host_model.sv
// Purpose: Host memory side of the descriptor walk
// Assumes: Bench holds go_i until the walk has begun
// Notes:   Idle data toggles so a stale word never looks valid
`timescale 1ns/1ps
module rxd_host_model (
  input  wire logic         clk_i,
  input  wire logic         go_i,
  input  wire logic         slow_i,
  input  wire logic [127:0] desc_i,
  input  wire logic         fetch_req_i,
  output logic              load_o = 1'b0,
  output logic      [2:0]   idx_o = 3'h0,
  output logic      [31:0]  data_o = 32'h0,
  output logic              valid_o = 1'b0,
  output logic              ready_o = 1'b1
);
  int   n = 0;
  logic act;

  // load words 0..3, then one valid pulse
  always @(posedge clk_i)
  begin
    act = go_i && fetch_req_i && (n < 5);
    load_o  <= act && (n < 4);
    valid_o <= act && (n == 4);
    idx_o   <= 3'(n);
    data_o  <= (act && n < 4) ? desc_i[32*(n%4) +: 32] : ~data_o;
    ready_o <= !slow_i || ($urandom_range(1) == 1);  // Slow mode stalls write-back
    n = !go_i ? 0 : n + int'(act);
  end
endmodule : rxd_host_model

//--- tb/testbench.sv
// Purpose: Self-checking bench for the descriptor engine
// Assumes: Host model serves each fetch
// Notes:   Driver queues notes, monitor pops them
`timescale 1ns/1ps
module testbench;
  localparam logic [31:0] BASE = 32'h0000_1000;
  logic                clk_i = 1'b0, arst_n_i = 1'b0, go = 1'b0, sw = 1'b0, pl = 1'b0;
  logic                bf = 1'b0, fl = 1'b0, enh = 1'b0, slow = 1'b0, wk = 1'b0, wkm = 1'b0;
  logic [3:0]          mf = 4'h0, mm = 4'h0;
  logic [7:0]          de = 8'h0, den = 8'h0, dcl = 8'h0, ds;
  logic [31:0]         cur, fa, sa, na, lw, b2a;
  logic [127:0]        desc = 128'h0;
  rxd_pkg::rxd_frame_t fr = '0;
  rxd_pkg::rxd_wb_t    wb;
  logic                ld, dv, rdy, fq, swb, se, b2e, nv, pd, ns, as, irq, wirq;
  logic [2:0]          li;
  logic [39:0]         q[$];
  int                  err_count = 0;
  int                  n_tests = 0;

  rxd_engine dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .desc_base_i(BASE),
    .descriptor_format_mode_i(enh), .sw_reset_req_i(sw), .software_reset_bit_o(swb),
    .fetch_req_o(fq), .fetch_addr_o(fa), .desc_load_i(ld), .desc_load_idx_i(li),
    .desc_load_data_i(lw), .desc_valid_i(dv), .store_en_o(se), .store_addr_o(sa),
    .buf2_en_o(b2e), .buf2_addr_o(b2a), .buf_full_i(bf), .frame_last_i(fl), .frame_i(fr),
    .wb_o(wb), .wb_ready_i(rdy), .next_valid_o(nv), .next_addr_o(na),
    .tx_poll_write_i(pl), .tx_poll_demand_o(pd), .mac_flags_i(mf), .mac_mask_i(mm),
    .dma_evt_i(de), .dma_en_i(den), .dma_clr_i(dcl), .dma_status_o(ds),
    .normal_sum_o(ns), .abnormal_sum_o(as), .wake_evt_i(wk), .wake_mask_i(wkm),
    .irq_o(irq), .wake_irq_o(wirq));

  rxd_host_model host_u (.clk_i(clk_i), .go_i(go), .slow_i(slow), .desc_i(desc),
    .fetch_req_i(fq), .load_o(ld), .idx_o(li), .data_o(lw), .valid_o(dv), .ready_o(rdy));

  // 125 MHz clock
  initial
    forever #4 clk_i = ~clk_i;

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // Oldest note against each word seen; empty queue gives a sentinel
  task automatic pop(input logic [39:0] g);
    chk("wb", (q.size() > 0) ? q.pop_front() : 40'hee_0000_0000, g);
  endtask : pop

  always @(posedge clk_i)
  begin
    if (wb.valid === 1'b1 && rdy === 1'b1)
      pop({5'h0, wb.idx, wb.data});
    if (nv === 1'b1)
      pop({8'hff, na});
  end

  // One descriptor: mode, chain, ring end from i; i[3] forces a timestamp except on a normal-mode chain
  task automatic walk(input logic [3:0] i);
    logic                e, ch, re, tk, lst, he, pe;
    logic [12:0]         s1;
    logic [31:0]         w1, w2, w3, st, w4, nx;
    logic [191:0]        r;
    rxd_pkg::rxd_frame_t f;
    {e, re, ch} = i[2:0];
    lst = (i != 4'h6);
    s1 = (i == 4'h5) ? 13'h0 : 13'($urandom_range(1, 2047) << 2);
    w1 = {3'h0, 13'h100, re, ch, 1'b0, s1};
    w2 = $urandom;
    w3 = 32'h0000_4000 + ($urandom_range(255) << 5);
    r = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
    f = r[$bits(f)-1:0];
    if (i[3])
      {f.ts_en, f.filt_pass, f.snap_hit} = 3'h7;
    f.snap_hit &= (e | !ch);  // Normal chain keeps its link word
    tk = f.ts_en & f.filt_pass & f.snap_hit & lst;
    f.status0 &= 32'h7fff_fe7e;
    f.ipv4_frame_flag = !f.ipv6_frame_flag;
    f.ether_type = f.ipv6_frame_flag ? 16'h86dd : 16'h0800;
    f.ip_ver = r[191] ? 4'h4 : 4'h6;
    if (r[190])
      f.pld_len = f.ip_len;
    he = f.ip_hdr_cksum_bad | (f.ip_ver != (f.ipv6_frame_flag ? 4'h6 : 4'h4));
    pe = f.l4_cksum_bad | (f.ip_len != f.pld_len);
    w4 = {18'h0, f.ptp_version_flag, f.ptp_over_ethernet_flag, f.ptp_message_type_field,
      f.ipv6_frame_flag, f.ipv4_frame_flag, f.checksum_bypassed_flag, pe, he,
      (f.checksum_offload_enable & !he) ? f.pld_type : 3'h0};
    st = f.status0 | {23'h0, lst, e & tk, 6'h0, e & lst};
    nx = re ? BASE : ch ? w3 : cur + (e ? 32'h20 : 32'h10);
    q.push_back({8'h0, st});
    if (!e && tk)
      q.push_back({8'h2, f.ts[31:0]});
    if (!e && tk)
      q.push_back({8'h3, f.ts[63:32]});
    if (e && lst)
      q.push_back({8'h4, w4});
    if (e && tk)
      q.push_back({8'h6, f.ts[31:0]});
    if (e && tk)
      q.push_back({8'h7, f.ts[63:32]});
    q.push_back({8'hff, nx});
    enh <= e;
    slow <= i[0];
    desc <= {w3, w2, w1, 32'h8000_0000};
    fr <= f;
    go <= 1'b1;
    tick(14);
    chk("buf", {6'h0, s1 != 13'h0, !ch, w2}, {6'h0, se, b2e, sa});
    chk("buf2", {8'h0, w3}, {8'h0, b2a});
    chk("fetch", {8'h0, cur}, {8'h0, fa});
    fl <= lst;
    bf <= !lst;
    tick(1);
    fl <= 1'b0;
    bf <= 1'b0;
    go <= 1'b0;
    for (int k = 0; k < 80 && nv !== 1'b1; k++)
      tick(1);
    tick(1);
    chk("left", 40'h0, 40'(q.size()));
    cur = nx;
  endtask : walk

  initial
  begin
    void'($urandom(50944));
    cur = BASE;
    tick(10);
    arst_n_i <= 1'b1;
    tick(7);
    chk("swr", 40'h1, {39'h0, swb});
    tick(3);
    chk("swr", 40'h0, {39'h0, swb});
    sw <= 1'b1;
    tick(1);
    sw <= 1'b0;
    tick(2);
    chk("swr", 40'h1, {39'h0, swb});
    tick(10);
    chk("fetch", {7'h0, 1'b1, BASE}, {7'h0, fq, fa});
    pl <= 1'b1;
    tick(1);
    pl <= 1'b0;
    tick(1);
    chk("poll", 40'h1, {39'h0, pd});
    for (int k = 0; k < 8; k++)
    begin
      den <= 8'h1 << k;
      de <= 8'h1 << k;
      tick(1);
      de <= 8'h0;
      tick(2);
      chk("evt", {29'h0, k < 4, k >= 4, 1'b1, 8'h1 << k}, {29'h0, ns, as, irq, ds});
      dcl <= 8'h1 << k;
      tick(1);
      dcl <= 8'h0;
      tick(2);
      chk("clr", 40'h0, {31'h0, ns | as, ds});
    end
    // Set and clear in one cycle; the set must survive
    de <= 8'h2;
    dcl <= 8'h2;
    tick(1);
    de <= 8'h0;
    dcl <= 8'h0;
    tick(1);
    chk("setwin", 40'h2, {32'h0, ds});
    mf <= 4'h5;
    mm <= 4'h5;
    tick(3);
    chk("mac", 40'h0, {39'h0, irq});
    mm <= 4'h4;
    tick(3);
    chk("mac", 40'h1, {39'h0, irq});
    mf <= 4'h0;
    wk <= 1'b1;
    tick(3);
    chk("wake", 40'h3, {38'h0, irq, wirq});
    wkm <= 1'b1;
    tick(3);
    chk("wake", 40'h1, {38'h0, irq, wirq});
    wk <= 1'b0;
    desc <= 128'h0;
    go <= 1'b1;
    tick(14);
    chk("own", 40'h1, {38'h0, se, ds[4]});
    go <= 1'b0;
    dcl <= 8'h10;
    tick(1);
    dcl <= 8'h0;
    for (int i = 0; i < 16; i++)
      walk(4'(i));
    close_out();
  end

  // Tests need about 550 cycles; this waits far longer
  initial
  begin
    #100us;
    err_count++;
    close_out();
  end
endmodule : testbench
